// >>> lsds_classify.sv
// Instruction category to execution unit routing.
`timescale 1ns/100ps
module lsds_classify (
  // Decoded category.
  input wire lsds_pkg::lsds_cat_e i_cat,
  // Unit needs.
  output lsds_pkg::lsds_route_s o_route
);

  ////////////////////////////////////////////////////////////////////////////////
  // The block holds no state, so the routing is one decode table.
  always_comb begin
    o_route = '0;
    o_route.fp = lsds_pkg::FP_NONE;
    o_route.n_ops = lsds_pkg::OPS_1;
    unique case (i_cat)
      lsds_pkg::CAT_INT_LOAD: begin
        // Address part plus load part.
        o_route.address_unit = 1'b1;
        o_route.load_store_unit = 1'b1;
        o_route.n_ops = lsds_pkg::OPS_2;
      end
      lsds_pkg::CAT_INT_STORE: begin
        o_route.address_unit = 1'b1;
        o_route.load_store_unit = 1'b1;
        o_route.store = 1'b1;
        o_route.n_ops = lsds_pkg::OPS_2;
      end
      lsds_pkg::CAT_INT_ALU: o_route.integer_exec_unit = 1'b1;
      lsds_pkg::CAT_INT_ADDR: o_route.address_unit = 1'b1;
      lsds_pkg::CAT_INT_MUL: begin
        // Multiplies go through the microcoded path.
        o_route.mul = 1'b1;
        o_route.microcoded = 1'b1;
      end
      lsds_pkg::CAT_INT_RMW: begin
        // One fused operation with address, execute and memory parts.
        o_route.address_unit = 1'b1;
        o_route.integer_exec_unit = 1'b1;
        o_route.load_store_unit = 1'b1;
        o_route.store = 1'b1;
        o_route.fused = 1'b1;
      end
      lsds_pkg::CAT_INT_LOAD_OP: begin
        // Load-execute: one operation with a load and an arithmetic part.
        o_route.address_unit = 1'b1;
        o_route.load_store_unit = 1'b1;
        o_route.integer_exec_unit = 1'b1;
      end
      lsds_pkg::CAT_INT_CMP_MEM: begin
        // Address, load and compare as three operations.
        o_route.address_unit = 1'b1;
        o_route.load_store_unit = 1'b1;
        o_route.integer_exec_unit = 1'b1;
        o_route.microcoded = 1'b1;
        o_route.n_ops = lsds_pkg::OPS_3;
      end
      lsds_pkg::CAT_FP_LOAD, lsds_pkg::CAT_FP_STORE, lsds_pkg::CAT_FP_MISC:
        o_route.fp = lsds_pkg::FP_STORE_PIPE;
      lsds_pkg::CAT_FP_MUL: o_route.fp = lsds_pkg::FP_MUL_PIPE;
      lsds_pkg::CAT_FP_ARITH: o_route.fp = lsds_pkg::FP_ADD_PIPE;
      default: o_route.integer_exec_unit = 1'b1; // Illegal code: treat as plain integer work.
    endcase
  end

endmodule

// >>> lsds_dc_model.sv
// Data cache model that answers each probed load in its access cycle.
`timescale 1ns/100ps
module lsds_dc_model (
  // Probe from the scheduler.
  input wire lsds_pkg::lsds_probe_s [lsds_pkg::SCAN_W-1:0] i_req,
  // Load data back to the scheduler.
  output logic [lsds_pkg::SCAN_W-1:0] o_rsp_valid,
  output logic [lsds_pkg::SCAN_W-1:0][lsds_pkg::TAG_W-1:0] o_rsp_tag,
  output logic [lsds_pkg::SCAN_W-1:0][lsds_pkg::ADDR_W-1:0] o_rsp_data
);
  // Every probe hits at once, so fused read-modify-write operations get their data too.
  // Idle lanes carry inverted data so stale values never look good.
  always_comb begin
    for (int i = 0; i < lsds_pkg::SCAN_W; i++) begin
      o_rsp_valid[i] = i_req[i].valid;
      o_rsp_tag[i] = i_req[i].tag;
      o_rsp_data[i] = o_rsp_valid[i] ? i_req[i].addr : ~i_req[i].addr;
    end
  end
endmodule

// >>> lsds_pkg.sv
// Shared constants and types of the load/store dispatch scheduler.
package lsds_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Sizes and timing.

  localparam int RQ_DEPTH = 12; // Entries of the memory reservation queue.
  localparam int RQ_IDX_W = $clog2(RQ_DEPTH); // Width of a queue index.
  localparam int RQ_CNT_W = $clog2(RQ_DEPTH + 1); // Width of the queue fill count.
  localparam int SCAN_W = 2; // Memory operations scanned out per cycle at most.
  localparam int NPIPE = 3; // Decode pipes, each with one integer and one address unit.
  localparam int PIPE_W = 2; // Width of a decode pipe number.
  localparam int MUL_LAT = 4; // Cycles from multiply start to result.
  localparam int MUL_CNT_W = $clog2(MUL_LAT + 1); // Width of the multiply counter.
  localparam int TAG_W = 6; // Width of an operation tag.
  localparam int ADDR_W = 32; // Width of an address and of forwarded data.
  localparam logic [PIPE_W-1:0] MUL_PIPE = 2'h0; // Pipe that owns microcoded multiplies.

  // Primitive operation counts produced by decode.
  localparam logic [1:0] OPS_1 = 2'h1;
  localparam logic [1:0] OPS_2 = 2'h2;
  localparam logic [1:0] OPS_3 = 2'h3;

  ////////////////////////////////////////////////////////////////////////////////
  // Types.

  // Category of a decoded instruction.
  typedef enum logic [3:0] {
    CAT_INT_LOAD, CAT_INT_STORE, CAT_INT_ALU, CAT_INT_ADDR, CAT_INT_MUL,
    CAT_INT_RMW, CAT_INT_LOAD_OP, CAT_INT_CMP_MEM,
    CAT_FP_LOAD, CAT_FP_STORE, CAT_FP_MISC, CAT_FP_MUL, CAT_FP_ARITH
  } lsds_cat_e;

  // Floating-point and packed-media pipe targets.
  typedef enum logic [1:0] {FP_NONE, FP_STORE_PIPE, FP_MUL_PIPE, FP_ADD_PIPE} lsds_fp_e;

  // Unit needs of one decoded instruction.
  typedef struct packed {
    logic address_unit;
    logic load_store_unit;
    logic integer_exec_unit;
    logic mul;
    logic store;
    logic fused;
    logic microcoded;
    lsds_fp_e fp;
    logic [1:0] n_ops;
  } lsds_route_s;

  // One lane of the queue scan and the cache probe pipeline.
  typedef struct packed {
    logic valid;
    logic store;
    logic wide;
    logic [TAG_W-1:0] tag;
    logic [ADDR_W-1:0] addr;
  } lsds_probe_s;

endpackage

// >>> lsds_resq.sv
// In-order memory reservation queue with out-of-order address capture.
`timescale 1ns/100ps
module lsds_resq (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rstn,
  // Scheduler side.
  lsds_rq_if.queue rq
);
  localparam int IW = lsds_pkg::RQ_IDX_W;
  localparam int CW = lsds_pkg::RQ_CNT_W;
  localparam int DEP = lsds_pkg::RQ_DEPTH;

  // One queued memory operation.
  typedef struct packed {
    logic valid;
    logic addr_ok;
    logic store;
    logic wide;
    logic [lsds_pkg::TAG_W-1:0] tag;
    logic [lsds_pkg::ADDR_W-1:0] addr;
  } lsds_rqe_s;

  // Whole queue state.
  typedef struct packed {
    lsds_rqe_s [DEP-1:0] ent;
    logic [IW-1:0] head;
    logic [IW-1:0] tail;
    logic [CW-1:0] count;
  } lsds_rq_s;

  lsds_rq_s st_r, st_nxt; // Registered state and its next value.
  lsds_rqe_s [DEP-1:0] cur; // Entries with this cycle's addresses merged in.
  logic [IW-1:0] idx0, idx1; // Oldest and second oldest slots.
  logic take0, take1; // Scan-out of the two oldest slots.
  logic alloc; // Allocation taken this cycle.

  // Advances a circular index.
  function automatic logic [IW-1:0] idx_inc(input logic [IW-1:0] i);
    if (i == IW'(DEP - 1)) begin
      return '0;
    end
    return i + IW'(1);
  endfunction

  // Two loads, a load with a store, or two narrow stores may pair.
  function automatic logic mix_ok(input lsds_rqe_s a, input lsds_rqe_s b);
    return !(a.store && b.store && (a.wide || b.wide));
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  always_comb begin
    cur = st_r.ent;
    // Addresses arrive in any order and are matched by tag.
    for (int i = 0; i < DEP; i++) begin
      for (int p = 0; p < lsds_pkg::NPIPE; p++) begin
        if (cur[i].valid && rq.agen_valid[p] && cur[i].tag == rq.agen_tag[p]) begin
          cur[i].addr_ok = 1'b1;
          cur[i].addr = rq.agen_addr[p];
        end
      end
    end
    // Scan strictly from the head; a ready younger entry waits for older.
    // The merged view lets an address scan out in the cycle it is made.
    idx0 = st_r.head;
    idx1 = idx_inc(st_r.head);
    take0 = cur[idx0].valid && cur[idx0].addr_ok;
    take1 = take0 && cur[idx1].valid && cur[idx1].addr_ok && mix_ok(cur[idx0], cur[idx1]);
    alloc = rq.alloc_valid && rq.alloc_ready;
    st_nxt = st_r;
    st_nxt.ent = cur;
    // Scanned entries are freed at once.
    if (take0) begin
      st_nxt.ent[idx0].valid = 1'b0;
    end
    if (take1) begin
      st_nxt.ent[idx1].valid = 1'b0;
    end
    st_nxt.head = take1 ? idx_inc(idx1) : (take0 ? idx1 : st_r.head);
    // Allocation in program order at the tail.
    if (alloc) begin
      st_nxt.ent[st_r.tail].valid = 1'b1;
      st_nxt.ent[st_r.tail].addr_ok = 1'b0;
      st_nxt.ent[st_r.tail].store = rq.alloc_store;
      st_nxt.ent[st_r.tail].wide = rq.alloc_wide;
      st_nxt.ent[st_r.tail].tag = rq.alloc_tag;
      st_nxt.ent[st_r.tail].addr = '0;
      st_nxt.tail = idx_inc(st_r.tail);
    end
    st_nxt.count = st_r.count + CW'(alloc) - CW'(take0) - CW'(take1);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Full queue refuses allocation until a scan frees an entry.
  assign rq.alloc_ready = (st_r.count != CW'(DEP));

  // Scan lanes toward the probe pipeline.
  assign rq.scan[0] = '{valid: take0, store: cur[idx0].store, wide: cur[idx0].wide,
                        tag: cur[idx0].tag, addr: cur[idx0].addr};
  assign rq.scan[1] = '{valid: take1, store: cur[idx1].store, wide: cur[idx1].wide,
                        tag: cur[idx1].tag, addr: cur[idx1].addr};

endmodule

// >>> lsds_rq_if.sv
// Link between the scheduler core and its memory reservation queue.
`timescale 1ns/100ps
interface lsds_rq_if;
  logic alloc_valid; // Allocate one entry at the tail.
  logic alloc_ready; // Queue has a free entry.
  logic alloc_store; // Entry is a store.
  logic alloc_wide; // Entry moves 64 bits.
  logic [lsds_pkg::TAG_W-1:0] alloc_tag; // Tag of the new entry.
  logic [lsds_pkg::NPIPE-1:0] agen_valid; // Address computed by address unit of a pipe.
  logic [lsds_pkg::NPIPE-1:0][lsds_pkg::TAG_W-1:0] agen_tag; // Tag owning the address.
  logic [lsds_pkg::NPIPE-1:0][lsds_pkg::ADDR_W-1:0] agen_addr; // Computed address.
  lsds_pkg::lsds_probe_s [lsds_pkg::SCAN_W-1:0] scan; // Operations scanned out this cycle.
  modport owner(output alloc_valid, alloc_store, alloc_wide, alloc_tag, agen_valid,
    agen_tag, agen_addr, input alloc_ready, scan);
  modport queue(input alloc_valid, alloc_store, alloc_wide, alloc_tag, agen_valid,
    agen_tag, agen_addr, output alloc_ready, scan);
endinterface

// >>> lsds_sva.sv
// Concurrent checks on the ports of the load/store dispatch scheduler.
`timescale 1ns/100ps
module lsds_sva (
  // Clock, reset and dispatch.
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_disp_valid,
  input wire lsds_pkg::lsds_cat_e i_disp_cat,
  input wire logic o_disp_ready,
  // Watched outputs.
  input wire logic o_mul_start,
  input wire logic o_mul_done,
  input wire logic o_fp_valid,
  input wire lsds_pkg::lsds_fp_e o_fp_pipe,
  input wire lsds_pkg::lsds_probe_s [lsds_pkg::SCAN_W-1:0] o_dc_req
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  logic tk; // High when a dispatch is taken at this edge.
  assign tk = i_disp_valid && o_disp_ready;
  chk_mul_lat: assert property (o_mul_start |-> ##4 o_mul_done)
    else $error("multiply result not four cycles after start.");
  chk_mul_cause: assert property (o_mul_done |-> $past(o_mul_start, 4))
    else $error("multiply result without a start four cycles before.");
  chk_fp_add: assert property (tk && i_disp_cat == lsds_pkg::CAT_FP_ARITH
    |=> o_fp_valid && o_fp_pipe == lsds_pkg::FP_ADD_PIPE) else $error("fp arith misrouted.");
  chk_fp_mul: assert property (tk && i_disp_cat == lsds_pkg::CAT_FP_MUL
    |=> o_fp_valid && o_fp_pipe == lsds_pkg::FP_MUL_PIPE) else $error("fp mul misrouted.");
  chk_fp_store: assert property (tk && i_disp_cat inside {lsds_pkg::CAT_FP_LOAD,
    lsds_pkg::CAT_FP_STORE, lsds_pkg::CAT_FP_MISC}
    |=> o_fp_valid && o_fp_pipe == lsds_pkg::FP_STORE_PIPE) else $error("fp store misrouted.");
  chk_int_no_fp: assert property (tk && i_disp_cat < lsds_pkg::CAT_FP_LOAD
    |=> !o_fp_valid) else $error("integer op sent to fp pipe.");
  chk_scan_order: assert property (o_dc_req[1].valid |-> o_dc_req[0].valid)
    else $error("second lane scanned alone.");
  chk_scan_mix: assert property (o_dc_req[0].valid && o_dc_req[1].valid
    && o_dc_req[0].store && o_dc_req[1].store |-> !(o_dc_req[0].wide || o_dc_req[1].wide))
    else $error("two stores paired with a wide one.");
endmodule

// >>> lsds_tb.sv
// Self-checking testbench of the load/store dispatch scheduler.
`timescale 1ns/100ps
module tb;
  logic i_clk = 1'h0, i_rstn = 1'h0, i_disp_valid = 1'h0, i_disp_wide = 1'h1;
  logic i_disp_src_wait = 1'h0, i_disp_base_wait = 1'h0, i_wb_valid = 1'h0;
  lsds_pkg::lsds_cat_e i_disp_cat = lsds_pkg::CAT_INT_ALU;
  logic [1:0] i_disp_pipe = 2'h0;
  logic [5:0] i_disp_tag = 6'h0, i_disp_src_tag = 6'h0, i_disp_base_tag = 6'h0, i_wb_tag = 6'h0;
  logic [31:0] i_disp_base = 32'h1000, i_disp_disp = 32'h0, i_wb_data = 32'h1000;
  logic o_disp_ready, o_mul_start, o_mul_done, o_fp_valid;
  logic [2:0] o_ieu_valid;
  logic [2:0][5:0] o_ieu_tag;
  logic [5:0] o_mul_tag, o_fp_tag;
  lsds_pkg::lsds_fp_e o_fp_pipe;
  lsds_pkg::lsds_probe_s [1:0] o_dc_req;
  logic [1:0] i_dc_rsp_valid;
  logic [1:0][5:0] i_dc_rsp_tag;
  logic [1:0][31:0] i_dc_rsp_data;
  int fails = 0, check_count = 0, cyc = 0;
  lsds_top lsds_top_inst (.*);
  lsds_dc_model lsds_dc_model_inst (.i_req(o_dc_req), .o_rsp_valid(i_dc_rsp_valid),
    .o_rsp_tag(i_dc_rsp_tag), .o_rsp_data(i_dc_rsp_data));
  initial forever #4 i_clk = ~i_clk;
  // A hang counts as a mismatch and ends the run.
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      results();
    end
  end
  task results;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(string n, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task tick(int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // Holds one dispatch until taken; valid stays up for back-to-back use.
  task automatic disp(lsds_pkg::lsds_cat_e c, logic [1:0] p, logic [5:0] t,
    logic bw = 1'h0, logic [5:0] st = 6'h0, logic sw = 1'h0);
    int n = 0;
    i_disp_valid <= 1'h1; i_disp_cat <= c; i_disp_pipe <= p; i_disp_tag <= t;
    i_disp_src_wait <= sw; i_disp_base_wait <= bw; i_disp_src_tag <= st;
    i_disp_base_tag <= st; i_disp_disp <= {26'h0, t};
    do @(negedge i_clk); while (o_disp_ready !== 1'h1 && ++n < 99);
    @(posedge i_clk);
  endtask
  task s_alu;
    @(posedge i_clk);
    disp(lsds_pkg::CAT_INT_ALU, 2'h1, 6'h01);
    i_disp_valid <= 1'h0;
    tick(1);
    chk("ieu1 valid", 1, o_ieu_valid[1]);
    chk("ieu1 tag", 6'h01, o_ieu_tag[1]);
  endtask
  task automatic s_fp;
    logic [1:0] ex [5] = '{2'h1, 2'h1, 2'h1, 2'h2, 2'h3};
    for (int i = 0; i < 5; i++) begin
      @(posedge i_clk);
      disp(lsds_pkg::lsds_cat_e'(lsds_pkg::CAT_FP_LOAD + i), 2'h0, 6'h08 + 6'(i));
      i_disp_valid <= 1'h0;
      tick(0);
      chk("fp valid", 1, o_fp_valid);
      chk("fp pipe", ex[i], o_fp_pipe);
      chk("fp tag", 6'h08 + 6'(i), o_fp_tag);
    end
  endtask
  task s_mul;
    @(posedge i_clk);
    disp(lsds_pkg::CAT_INT_MUL, 2'h2, 6'h10);
    disp(lsds_pkg::CAT_INT_ALU, 2'h0, 6'h11, 1'h0, 6'h10, 1'h1);
    i_disp_valid <= 1'h0;
    tick(0);
    for (int n = 0; n < 20 && o_mul_start !== 1'h1; n++) tick(1);
    chk("mul tag", 6'h10, o_mul_tag);
    tick(4);
    chk("mul done", 1, o_mul_done);
    tick(2);
    chk("dep issue", 1, o_ieu_valid[0]);
    chk("dep tag", 6'h11, o_ieu_tag[0]);
  endtask
  task s_load;
    @(posedge i_clk);
    disp(lsds_pkg::CAT_INT_LOAD, 2'h1, 6'h20);
    disp(lsds_pkg::CAT_INT_LOAD_OP, 2'h2, 6'h21);
    disp(lsds_pkg::CAT_INT_RMW, 2'h0, 6'h22);
    i_disp_valid <= 1'h0;
    tick(0);
    chk("probe tag", 6'h20, o_dc_req[0].tag);
    chk("probe addr", 32'h1020, o_dc_req[0].addr);
    tick(1);
    chk("probe next", 6'h21, o_dc_req[0].tag);
    tick(1);
    chk("ldop issue", 1, o_ieu_valid[2]);
    tick(1);
    chk("rmw issue", 1, o_ieu_valid[0]);
  endtask
  task automatic s_queue;
    int k = 0;
    @(posedge i_clk);
    for (int i = 0; i < 12; i++) begin
      i_disp_wide <= (i < 3);
      disp((i > 0 && i < 5) ? lsds_pkg::CAT_INT_STORE : lsds_pkg::CAT_INT_LOAD,
        2'(i % 3), 6'h30 + 6'(i), i == 0, 6'h3f);
    end
    i_disp_valid <= 1'h0;
    tick(3);
    chk("ready full", 0, o_disp_ready);
    chk("no early probe", 0, o_dc_req[0].valid);
    @(posedge i_clk);
    i_wb_valid <= 1'h1; i_wb_tag <= 6'h3f;
    @(posedge i_clk);
    i_wb_valid <= 1'h0;
    repeat (12) begin
      tick(1);
      for (int l = 0; l < 2; l++) if (o_dc_req[l].valid === 1'h1) begin
        chk("scan tag", 6'h30 + k, o_dc_req[l].tag);
        k++;
      end
    end
    chk("scan count", 12, k);
    chk("ready again", 1, o_disp_ready);
  endtask
  initial begin
    repeat (12) @(posedge i_clk);
    i_rstn <= 1'h1;
    s_alu(); s_fp(); s_mul(); s_load(); s_queue();
    results();
  end
endmodule
bind lsds_top lsds_sva lsds_sva_inst (.*);

// >>> lsds_top.sv
// Load/store dispatch scheduler: routing, reservation stations and cache probe.
//
// Function
// - Integer work routed to its unit type.
// - Floating-point work routed by category to pipes.
// - Read-modify-write becomes one fused operation.
// - Register-memory compare yields three operations.
// - Cache lookup in three stages.
// - Memory operations queued in order, twelve entries.
// - Cache probed in program order.
// - Scan-out frees entry, enters probe stages.
// - At most two scans per cycle.
// - Allowed mixes: two loads, load+store, narrow stores.
// - Multiply alone in pipe zero, four cycles.
// - Dependent operation waits for its source.
// - Busy integer unit delays operation.
// - Decode pipe selects integer and address unit.
// - Ready load waits behind older scan slot.
// - Load-execute arithmetic runs after cache access.
// - Address and scan in same cycle.
// - Address waits for pending base register.
// - Waiting operations capture returned load data.
`timescale 1ns/100ps
module lsds_top #(
  parameter int RS_DEPTH = 8 // Reservation station entries.
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rstn,
  // Dispatch from decode.
  input wire logic i_disp_valid,
  input wire lsds_pkg::lsds_cat_e i_disp_cat,
  input wire logic [lsds_pkg::PIPE_W-1:0] i_disp_pipe,
  input wire logic [lsds_pkg::TAG_W-1:0] i_disp_tag,
  input wire logic i_disp_wide,
  input wire logic i_disp_src_wait,
  input wire logic [lsds_pkg::TAG_W-1:0] i_disp_src_tag,
  input wire logic i_disp_base_wait,
  input wire logic [lsds_pkg::TAG_W-1:0] i_disp_base_tag,
  input wire logic [lsds_pkg::ADDR_W-1:0] i_disp_base,
  input wire logic [lsds_pkg::ADDR_W-1:0] i_disp_disp,
  output logic o_disp_ready,
  // Result bus of the execution units.
  input wire logic i_wb_valid,
  input wire logic [lsds_pkg::TAG_W-1:0] i_wb_tag,
  input wire logic [lsds_pkg::ADDR_W-1:0] i_wb_data,
  // Integer execution issue, one lane per decode pipe.
  output logic [lsds_pkg::NPIPE-1:0] o_ieu_valid,
  output logic [lsds_pkg::NPIPE-1:0][lsds_pkg::TAG_W-1:0] o_ieu_tag,
  // Multiplier.
  output logic o_mul_start,
  output logic o_mul_done,
  output logic [lsds_pkg::TAG_W-1:0] o_mul_tag,
  // Floating-point routing.
  output logic o_fp_valid,
  output lsds_pkg::lsds_fp_e o_fp_pipe,
  output logic [lsds_pkg::TAG_W-1:0] o_fp_tag,
  // Data cache access stage.
  output lsds_pkg::lsds_probe_s [lsds_pkg::SCAN_W-1:0] o_dc_req,
  input wire logic [lsds_pkg::SCAN_W-1:0] i_dc_rsp_valid,
  input wire logic [lsds_pkg::SCAN_W-1:0][lsds_pkg::TAG_W-1:0] i_dc_rsp_tag,
  input wire logic [lsds_pkg::SCAN_W-1:0][lsds_pkg::ADDR_W-1:0] i_dc_rsp_data
);
  localparam int TW = lsds_pkg::TAG_W;
  localparam int AW = lsds_pkg::ADDR_W;
  localparam int NP = lsds_pkg::NPIPE;
  localparam int MW = lsds_pkg::MUL_CNT_W;
  localparam int PW = lsds_pkg::PIPE_W;

  // One reservation station entry.
  typedef struct packed {
    logic valid;
    logic [TW-1:0] tag;
    logic [PW-1:0] pipe;
    logic need_agu;
    logic need_ieu;
    logic need_mem;
    logic is_mul;
    logic src_wait;
    logic [TW-1:0] src_tag;
    logic base_wait;
    logic [TW-1:0] base_tag;
    logic [AW-1:0] base;
    logic [AW-1:0] disp;
    logic mem_done;
  } lsds_rse_s;

  // Whole scheduler state.
  typedef struct packed {
    lsds_rse_s [RS_DEPTH-1:0] rs;
    logic mul_busy;
    logic [MW-1:0] mul_cnt;
    logic [TW-1:0] mul_tag;
    logic mul_start;
    logic mul_done;
    logic [NP-1:0] ieu_v;
    logic [NP-1:0][TW-1:0] ieu_tag;
    logic fp_v;
    lsds_pkg::lsds_fp_e fp_pipe;
    logic [TW-1:0] fp_tag;
    lsds_pkg::lsds_probe_s [lsds_pkg::SCAN_W-1:0] s2; // Address transport stage.
    lsds_pkg::lsds_probe_s [lsds_pkg::SCAN_W-1:0] s3; // Cache access stage.
  } lsds_top_s;

  lsds_top_s st_r, st_nxt; // Registered state and its next value.
  lsds_pkg::lsds_route_s route; // Unit needs of the dispatched instruction.
  logic have_free; // A reservation station slot is free.
  logic disp_fire; // Dispatch accepted this cycle.
  logic [NP-1:0] agen_v; // Address unit results of this cycle.
  logic [NP-1:0][TW-1:0] agen_tag;
  logic [NP-1:0][AW-1:0] agen_addr;

  lsds_rq_if rq(); // Link to the reservation queue.

  ////////////////////////////////////////////////////////////////////////////////
  // Submodules.

  // Category decode.
  lsds_classify u_cls (
    .i_cat(i_disp_cat),
    .o_route(route)
  );

  // Memory reservation queue.
  lsds_resq u_rq (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .rq(rq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Load data for tag t is returned by the cache this cycle.
  function automatic logic dc_hit(input logic [TW-1:0] t);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < lsds_pkg::SCAN_W; k++) begin
      hit = hit | (i_dc_rsp_valid[k] && i_dc_rsp_tag[k] == t);
    end
    return hit;
  endfunction

  // Result for tag t appears on any result source this cycle.
  function automatic logic wake_hit(input logic [TW-1:0] t);
    return (i_wb_valid && i_wb_tag == t) || (st_r.mul_done && st_r.mul_tag == t) || dc_hit(t);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  always_comb begin
    logic agu_taken;
    logic ieu_taken;
    logic mul_taken;
    logic placed;
    lsds_rse_s e;
    agu_taken = 1'b0;
    ieu_taken = 1'b0;
    mul_taken = 1'b0;
    placed = 1'b0;
    e = '0;
    st_nxt = st_r;
    st_nxt.mul_start = 1'b0;
    st_nxt.mul_done = 1'b0;
    st_nxt.ieu_v = '0;
    st_nxt.fp_v = 1'b0;
    agen_v = '0;
    agen_tag = '0;
    agen_addr = '0;
    // Scanned operations move through transport and cache access.
    st_nxt.s2 = rq.scan;
    st_nxt.s3 = st_r.s2;
    // Multiply result comes a fixed time after the start.
    if (st_r.mul_busy) begin
      st_nxt.mul_cnt = st_r.mul_cnt - MW'(1);
      if (st_r.mul_cnt == MW'(1)) begin
        st_nxt.mul_busy = 1'b0;
        st_nxt.mul_done = 1'b1;
      end
    end
    // Each pipe owns one address unit and one integer unit.
    for (int p = 0; p < NP; p++) begin
      agu_taken = 1'b0;
      ieu_taken = 1'b0;
      for (int i = 0; i < RS_DEPTH; i++) begin
        e = st_r.rs[i];
        if (e.valid && e.pipe == PW'(p)) begin
          if (!agu_taken && e.need_agu && !e.base_wait) begin
            // Address only once the base register is known.
            agu_taken = 1'b1;
            agen_v[p] = 1'b1;
            agen_tag[p] = e.tag;
            agen_addr[p] = e.base + e.disp;
            st_nxt.rs[i].need_agu = 1'b0;
          end else if (e.need_ieu && !e.need_agu && !e.src_wait &&
                       (!e.need_mem || e.mem_done || dc_hit(e.tag))) begin
            if (!ieu_taken) begin
              ieu_taken = 1'b1;
              st_nxt.ieu_v[p] = 1'b1;
              st_nxt.ieu_tag[p] = e.tag;
              st_nxt.rs[i].need_ieu = 1'b0;
            end
            // A second ready entry of this pipe stays for a later cycle.
          end
        end
      end
    end
    // Single multiplier, started when its operands are ready.
    for (int i = 0; i < RS_DEPTH; i++) begin
      if (!mul_taken && !st_r.mul_busy && st_r.rs[i].valid && st_r.rs[i].is_mul &&
          !st_r.rs[i].src_wait) begin
        mul_taken = 1'b1;
        st_nxt.mul_busy = 1'b1;
        st_nxt.mul_start = 1'b1;
        st_nxt.mul_cnt = MW'(lsds_pkg::MUL_LAT);
        st_nxt.mul_tag = st_r.rs[i].tag;
        st_nxt.rs[i].is_mul = 1'b0;
      end
    end
    // Dispatch: floating-point work is routed by category.
    if (disp_fire && route.fp != lsds_pkg::FP_NONE) begin
      st_nxt.fp_v = 1'b1;
      st_nxt.fp_pipe = route.fp;
      st_nxt.fp_tag = i_disp_tag;
    end else if (disp_fire) begin
      for (int i = 0; i < RS_DEPTH; i++) begin
        if (!placed && !st_r.rs[i].valid) begin
          placed = 1'b1;
          st_nxt.rs[i].valid = 1'b1;
          st_nxt.rs[i].tag = i_disp_tag;
          // Microcoded multiply is bound to pipe zero.
          st_nxt.rs[i].pipe = route.mul ? lsds_pkg::MUL_PIPE : i_disp_pipe;
          st_nxt.rs[i].need_agu = route.address_unit;
          st_nxt.rs[i].need_ieu = route.integer_exec_unit;
          st_nxt.rs[i].need_mem = route.load_store_unit && route.integer_exec_unit;
          st_nxt.rs[i].is_mul = route.mul;
          st_nxt.rs[i].src_wait = i_disp_src_wait && (route.integer_exec_unit || route.mul);
          st_nxt.rs[i].src_tag = i_disp_src_tag;
          st_nxt.rs[i].base_wait = i_disp_base_wait && route.address_unit;
          st_nxt.rs[i].base_tag = i_disp_base_tag;
          st_nxt.rs[i].base = i_disp_base;
          st_nxt.rs[i].disp = i_disp_disp;
          st_nxt.rs[i].mem_done = 1'b0;
        end
      end
    end
    // Wake-up from results and returned load data; entries done are freed.
    for (int i = 0; i < RS_DEPTH; i++) begin
      if (st_nxt.rs[i].src_wait && wake_hit(st_nxt.rs[i].src_tag)) begin
        st_nxt.rs[i].src_wait = 1'b0;
      end
      if (st_nxt.rs[i].base_wait && i_wb_valid && i_wb_tag == st_nxt.rs[i].base_tag) begin
        st_nxt.rs[i].base_wait = 1'b0;
        st_nxt.rs[i].base = i_wb_data;
      end
      for (int k = 0; k < lsds_pkg::SCAN_W; k++) begin
        if (st_nxt.rs[i].base_wait && i_dc_rsp_valid[k] &&
            i_dc_rsp_tag[k] == st_nxt.rs[i].base_tag) begin
          st_nxt.rs[i].base_wait = 1'b0;
          st_nxt.rs[i].base = i_dc_rsp_data[k];
        end
      end
      if (st_nxt.rs[i].need_mem && dc_hit(st_nxt.rs[i].tag)) begin
        st_nxt.rs[i].mem_done = 1'b1;
      end
      if (st_nxt.rs[i].valid && !st_nxt.rs[i].need_agu && !st_nxt.rs[i].need_ieu &&
          !st_nxt.rs[i].is_mul) begin
        st_nxt.rs[i].valid = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Dispatch handshake and queue link.

  // Any free station slot.
  always_comb begin
    have_free = 1'b0;
    for (int i = 0; i < RS_DEPTH; i++) begin
      have_free = have_free | !st_r.rs[i].valid;
    end
  end

  // Dispatch stalls while the queue is full, whatever the category.
  assign o_disp_ready = have_free && rq.alloc_ready;
  assign disp_fire = i_disp_valid && o_disp_ready;

  // Memory parts enter the queue at dispatch, in order.
  assign rq.alloc_valid = disp_fire && route.load_store_unit && (route.fp == lsds_pkg::FP_NONE);
  assign rq.alloc_store = route.store;
  assign rq.alloc_wide = i_disp_wide;
  assign rq.alloc_tag = i_disp_tag;
  assign rq.agen_valid = agen_v;
  assign rq.agen_tag = agen_tag;
  assign rq.agen_addr = agen_addr;

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, all from the state register.
  assign o_ieu_valid = st_r.ieu_v;
  assign o_ieu_tag = st_r.ieu_tag;
  assign o_mul_start = st_r.mul_start;
  assign o_mul_done = st_r.mul_done;
  assign o_mul_tag = st_r.mul_tag;
  assign o_fp_valid = st_r.fp_v;
  assign o_fp_pipe = st_r.fp_pipe;
  assign o_fp_tag = st_r.fp_tag;
  assign o_dc_req = st_r.s3;

endmodule
